// >>> bench/flash_port_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module flash_port_checker
#(
    parameter int WRITE_CYCLES = 20,
    parameter int ERASE_CYCLES = 30
)
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       reset_vpp_pin,
    input wire logic       vpp_high_pin,
    input wire logic       pulse_a_strobe_pin,
    input wire logic       mode_line_a,
    input wire logic       mode_line_b,
    input wire logic       mode_line_c,
    input wire logic       mode_line_d,
    input wire logic       addr_step_pin,
    input wire logic [7:0] data_port_in,
    input wire logic [7:0] data_port_out_ff,
    input wire logic       data_port_oe_ff,
    input wire logic       ready_busy_pin_ff,
    input wire logic       device_reset_ff
);
    // Worst busy spell: full queue of writes plus an erase sweep
    localparam int BUSY_CAP = 8 * (WRITE_CYCLES + 2) + 2100 + ERASE_CYCLES;
    wire  [3:0]  mode = {mode_line_a, mode_line_b, mode_line_c, mode_line_d};
    logic [19:0] busy_cnt_ff;
    always @(posedge sys_clk)
    begin
        if (rst || ready_busy_pin_ff)
            busy_cnt_ff <= 20'h00000;
        else
            busy_cnt_ff <= busy_cnt_ff + 20'h00001;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ****
    // Checks
    // ****
    strobe_busy_a : assert property (
        $rose(pulse_a_strobe_pin) && !$past(rst) && reset_vpp_pin && vpp_high_pin
        && (mode == 4'h7 || mode == 4'hF || mode == 4'hC) && ready_busy_pin_ff
        |-> ##[1:2] !ready_busy_pin_ff) else $error("no busy after write");
    busy_cause_a : assert property ($fell(ready_busy_pin_ff) |->
        $past(pulse_a_strobe_pin, 1) && (!$past(pulse_a_strobe_pin, 2)
        || !$past(pulse_a_strobe_pin, 3))) else $error("busy without strobe");
    idle_ready_a : assert property (ready_busy_pin_ff && pulse_a_strobe_pin
        && $past(pulse_a_strobe_pin, 1) && $past(pulse_a_strobe_pin, 2)
        |=> ready_busy_pin_ff) else $error("busy while idle");
    write_min_a : assert property ($rose(ready_busy_pin_ff) |->
        busy_cnt_ff >= WRITE_CYCLES) else $error("write too short");
    busy_cap_a : assert property (busy_cnt_ff <= BUSY_CAP)
        else $error("busy never ends");
    read_drive_a : assert property (reset_vpp_pin && !vpp_high_pin
        && pulse_a_strobe_pin && mode == 4'h3 |=> data_port_oe_ff)
        else $error("code read not driven");
    sig_drive_a : assert property (reset_vpp_pin && !vpp_high_pin
        && pulse_a_strobe_pin && mode == 4'h0 |=> data_port_oe_ff)
        else $error("signature read not driven");
    no_drive_a : assert property (!reset_vpp_pin || vpp_high_pin
        || !pulse_a_strobe_pin |=> !data_port_oe_ff) else $error("port driven");
    reset_drop_a : assert property ($fell(reset_vpp_pin) |->
        ##[1:2] !device_reset_ff) else $error("device reset stuck");
    reset_rise_a : assert property ($rose(device_reset_ff) |->
        $past(reset_vpp_pin)) else $error("device reset without pin");
    busy_seen_c : cover property ($fell(ready_busy_pin_ff));
    sig_read_c : cover property (mode == 4'h0 && data_port_oe_ff);
    dev_reset_c : cover property ($rose(device_reset_ff));
endmodule // flash_port_checker

bind parallel_flash_programming_port flash_port_checker
#(
    .WRITE_CYCLES(WRITE_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
)
chk
(
    .sys_clk(sys_clk), .rst(rst), .reset_vpp_pin(reset_vpp_pin),
    .vpp_high_pin(vpp_high_pin), .pulse_a_strobe_pin(pulse_a_strobe_pin),
    .mode_line_a(mode_line_a), .mode_line_b(mode_line_b),
    .mode_line_c(mode_line_c), .mode_line_d(mode_line_d),
    .addr_step_pin(addr_step_pin), .data_port_in(data_port_in),
    .data_port_out_ff(data_port_out_ff), .data_port_oe_ff(data_port_oe_ff),
    .ready_busy_pin_ff(ready_busy_pin_ff), .device_reset_ff(device_reset_ff)
);
`default_nettype wire

// >>> bench/programmer_model.sv
`timescale 1ns/10ps
`default_nettype none
module programmer_model
(
    input  wire logic       sys_clk,
    input  wire logic       ready_busy_pin_ff,
    input  wire logic [7:0] data_port_out_ff,
    output var  logic       reset_vpp_pin,
    output var  logic       vpp_high_pin,
    output var  logic       pulse_a_strobe_pin,
    output var  logic       mode_line_a,
    output var  logic       mode_line_b,
    output var  logic       mode_line_c,
    output var  logic       mode_line_d,
    output var  logic       addr_step_pin,
    output var  logic [7:0] data_port_in
);
    // ****
    // Pin sequences
    // ****
    initial
    begin
        reset_vpp_pin = 1'b0;
        addr_step_pin = 1'b0;
        vpp_high_pin = 1'b0;
        pulse_a_strobe_pin = 1'b1;
        {mode_line_a, mode_line_b, mode_line_c, mode_line_d} = 4'hF;
        data_port_in = 8'hFF;
    end
    task automatic go(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic restart();
        go(1);
        reset_vpp_pin <= 1'b0;
        go(2);
        reset_vpp_pin <= 1'b1;
        pulse_a_strobe_pin <= 1'b1;
        go(2);
    endtask
    task automatic wr(input logic [3:0] m, input logic [7:0] d, input int low);
        go(1);
        {mode_line_a, mode_line_b, mode_line_c, mode_line_d} <= m;
        data_port_in <= d;
        vpp_high_pin <= 1'b1;
        go(2);
        pulse_a_strobe_pin <= 1'b0;
        go(low);
        pulse_a_strobe_pin <= 1'b1;
        go(2);
        // Released port must not look like the last byte
        data_port_in <= ~d;
        vpp_high_pin <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] m, output logic [7:0] d);
        go(1);
        {mode_line_a, mode_line_b, mode_line_c, mode_line_d} <= m;
        go(3);
        #1 d = data_port_out_ff;
    endtask
    task automatic wait_ready(output logic ok);
        int i;
        ok = 1'b0;
        for (i = 0; i < 4000 && ok !== 1'b1; i++)
        begin
            go(1);
            #1 ok = ready_busy_pin_ff;
        end
    endtask
    task automatic step(input int n);
        repeat (n)
        begin
            go(1);
            addr_step_pin <= 1'b1;
            go(1);
            addr_step_pin <= 1'b0;
        end
        go(2);
    endtask
    task automatic power_down();
        go(1);
        addr_step_pin <= 1'b0;
        go(1);
        reset_vpp_pin <= 1'b0;
        go(2);
    endtask
endmodule // programmer_model
`default_nettype wire

// >>> bench/test_parallel_flash_programming_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "flash_port_regs.vh"
module test_parallel_flash_programming_port;
    localparam int LIMIT = 30000;
    logic       sys_clk;
    logic       rst;
    wire        reset_vpp_pin;
    wire        vpp_high_pin;
    wire        pulse_a_strobe_pin;
    wire        mode_line_a;
    wire        mode_line_b;
    wire        mode_line_c;
    wire        mode_line_d;
    wire        addr_step_pin;
    wire  [7:0] data_port_in;
    wire  [7:0] data_port_out_ff;
    wire        data_port_oe_ff;
    wire        ready_busy_pin_ff;
    wire        device_reset_ff;
    logic [7:0] d;
    logic       ok;
    logic [7:0] sig [0:2];
    int         n_fail = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         i;
    // Short counts keep the run brief; signatures keep their arbitrary defaults
    parallel_flash_programming_port
    #(
        .WRITE_CYCLES(20), .ERASE_CYCLES(30)
    )
    dut
    (
        .sys_clk(sys_clk), .rst(rst), .reset_vpp_pin(reset_vpp_pin),
        .vpp_high_pin(vpp_high_pin), .pulse_a_strobe_pin(pulse_a_strobe_pin),
        .mode_line_a(mode_line_a), .mode_line_b(mode_line_b),
        .mode_line_c(mode_line_c), .mode_line_d(mode_line_d),
        .addr_step_pin(addr_step_pin), .data_port_in(data_port_in),
        .data_port_out_ff(data_port_out_ff), .data_port_oe_ff(data_port_oe_ff),
        .ready_busy_pin_ff(ready_busy_pin_ff), .device_reset_ff(device_reset_ff)
    );
    programmer_model pulse_a
    (
        .sys_clk(sys_clk), .ready_busy_pin_ff(ready_busy_pin_ff),
        .data_port_out_ff(data_port_out_ff), .reset_vpp_pin(reset_vpp_pin),
        .vpp_high_pin(vpp_high_pin), .pulse_a_strobe_pin(pulse_a_strobe_pin),
        .mode_line_a(mode_line_a), .mode_line_b(mode_line_b),
        .mode_line_c(mode_line_c), .mode_line_d(mode_line_d),
        .addr_step_pin(addr_step_pin), .data_port_in(data_port_in)
    );
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ****
    // Helpers
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [3:0] m, input logic [7:0] v, input int low);
        pulse_a.wr(m, v, low);
        pulse_a.wait_ready(ok);
        check({7'h00, ok}, 8'h01);
    endtask
    task automatic look(input logic [3:0] m, input logic [7:0] e);
        pulse_a.rd(m, d);
        check(d, e);
        check({7'h00, data_port_oe_ff}, 8'h01);
    endtask
    task automatic stop_test();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_fail++;
            stop_test();
        end
    end
    // ****
    // Sequence
    // ****
    initial
    begin
        sig[0] = 8'h5A;
        sig[1] = 8'h3C;
        sig[2] = 8'hC3;
        rst = 1'b1;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        pulse_a.restart();
        put(`MODE_CHIP_ERASE, 8'h00, 32);
        look(`MODE_READ_CODE, 8'hFF);
        pulse_a.wr(`MODE_WRITE_CODE, 8'hA5, 1);
        look(`MODE_READ_CODE, 8'h7F);
        check({7'h00, ready_busy_pin_ff}, 8'h00);
        pulse_a.wait_ready(ok);
        check({7'h00, ok}, 8'h01);
        look(`MODE_READ_CODE, 8'hA5);
        pulse_a.step(1);
        put(`MODE_WRITE_CODE, 8'h3C, 1);
        look(`MODE_READ_CODE, 8'h3C);
        pulse_a.restart();
        look(`MODE_READ_CODE, 8'hA5);
        put(`MODE_WRITE_CODE, 8'hFF, 1);
        look(`MODE_READ_CODE, 8'hA5);
        for (i = 0; i < 3; i++)
        begin
            pulse_a.restart();
            pulse_a.step(i);
            look(`MODE_READ_SIG, sig[i]);
        end
        put(`MODE_WRITE_LOCK1, 8'h00, 1);
        put(`MODE_WRITE_CODE, 8'h00, 1);
        look(`MODE_READ_CODE, 8'hFF);
        pulse_a.restart();
        look(`MODE_READ_CODE, 8'hA5);
        put(`MODE_WRITE_LOCK2, 8'h00, 1);
        look(`MODE_READ_CODE, 8'hFF);
        put(`MODE_CHIP_ERASE, 8'h00, 32);
        put(`MODE_WRITE_CODE, 8'h12, 1);
        look(`MODE_READ_CODE, 8'h12);
        pulse_a.step(1);
        put(`MODE_WRITE_CODE, 8'h34, 1);
        pulse_a.restart();
        pulse_a.step(2049);
        look(`MODE_READ_CODE, 8'h34);
        check({7'h00, device_reset_ff}, 8'h01);
        pulse_a.power_down();
        check({7'h00, device_reset_ff}, 8'h00);
        stop_test();
    end
endmodule // test_parallel_flash_programming_port
`default_nettype wire

// >>> rtl/flash_port_regs.vh
`ifndef FLASH_PORT_REGS_VH
`define FLASH_PORT_REGS_VH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CLK_PERIOD_NS       25
// Typical self-timed byte or lock-bit write
`define WRITE_TIME_NS       1200000
// Least strobe low time that starts a chip erase
`define ERASE_TIME_NS       10000000
`define WRITE_CYCLES        (`WRITE_TIME_NS / `CLK_PERIOD_NS)
`define ERASE_CYCLES        ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W             19
// Full device reset: two machine cycles of twelve oscillator periods
`define OSC_PER_MACHINE     12
`define RESET_MACHINE_CYC   2
`define RESET_OSC_EDGES     (`OSC_PER_MACHINE * `RESET_MACHINE_CYC)
`define OSC_CNT_W           5

// ****************************************************************
// Array geometry
// ****************************************************************
`define ADDR_W              11
`define DATA_W              8
`define ADDR_ZERO           11'h000
`define ERASED_BYTE         8'hFF
`define FIFO_DEPTH          8

// ****************************************************************
// Mode line codes, bit order {a, b, c, d}
// ****************************************************************
`define MODE_WRITE_CODE     4'h7
`define MODE_READ_CODE      4'h3
`define MODE_WRITE_LOCK1    4'hF
`define MODE_WRITE_LOCK2    4'hC
`define MODE_CHIP_ERASE     4'h8
`define MODE_READ_SIG       4'h0

// ****************************************************************
// Queued write operations
// ****************************************************************
`define OP_W                2
`define OP_CODE             2'h0
`define OP_LOCK1            2'h1
`define OP_LOCK2            2'h2

// ****************************************************************
// Signature locations
// ****************************************************************
`define SIG_ADDR_0          11'h000
`define SIG_ADDR_1          11'h001
`define SIG_ADDR_2          11'h002

`endif

// >>> rtl/parallel_flash_programming_port.v
`timescale 1ns/10ps
`default_nettype none
`include "flash_port_regs.vh"

module parallel_flash_programming_port
#(
    parameter WRITE_CYCLES = `WRITE_CYCLES,
    parameter ERASE_CYCLES = `ERASE_CYCLES,
    parameter FIFO_DEPTH   = `FIFO_DEPTH,
    parameter [7:0] SIG_0  = 8'h5A,  // Arbitrary value
    parameter [7:0] SIG_1  = 8'h3C,  // Arbitrary value
    parameter [7:0] SIG_2  = 8'hC3   // Arbitrary value
)
(
    input  wire                sys_clk,
    input  wire                rst,
    input  wire                reset_vpp_pin,
    input  wire                vpp_high_pin,
    input  wire                pulse_a_strobe_pin,
    input  wire                mode_line_a,
    input  wire                mode_line_b,
    input  wire                mode_line_c,
    input  wire                mode_line_d,
    input  wire                addr_step_pin,
    input  wire [`DATA_W-1:0]  data_port_in,
    output reg  [`DATA_W-1:0]  data_port_out_ff,
    output reg                 data_port_oe_ff,
    output reg                 ready_busy_pin_ff,
    output reg                 device_reset_ff
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam FIFO_W   = `OP_W + `ADDR_W + `DATA_W;
    localparam ARRAY_SZ = 1 << `ADDR_W;

    localparam ST_IDLE  = 2'd0;
    localparam ST_PULSE_A  = 2'd1;
    localparam ST_ERASE = 2'd2;

    reg [`DATA_W-1:0]    flash_mem [0:ARRAY_SZ-1];

    reg                  strobe_q_ff;
    reg                  step_q_ff;
    reg                  rstpin_q_ff;
    reg [`ADDR_W-1:0]    addr_ff;
    reg [`TIMER_W-1:0]   low_cnt_ff;
    reg [1:0]            state_ff;
    reg [1:0]            nxt_state;
    reg [`TIMER_W-1:0]   timer_ff;
    reg [`ADDR_W-1:0]    sweep_ff;
    reg [`OP_W-1:0]      op_ff;
    reg [`ADDR_W-1:0]    waddr_ff;
    reg [`DATA_W-1:0]    wdata_ff;
    reg                  lock_one_ff;
    reg                  lock_two_ff;
    reg [`ADDR_W-1:0]    last_addr_ff;
    reg [`DATA_W-1:0]    last_data_ff;
    reg [`OSC_CNT_W-1:0] osc_cnt_ff;

    reg                  mem_we;
    reg [`ADDR_W-1:0]    mem_waddr;
    reg [`DATA_W-1:0]    mem_wdata;
    reg                  push_ok;
    reg [`OP_W-1:0]      push_op;
    reg [`DATA_W-1:0]    sig_byte;

    wire [3:0]           mode;
    wire                 strobe_rise;
    wire                 step_rise;
    wire                 rstpin_rise;
    wire                 pulse_a_en;
    wire                 read_en;
    wire                 erase_go;
    wire                 push;
    wire                 fifo_in_ready;
    wire                 fifo_out_valid;
    wire                 fifo_out_ready;
    wire [FIFO_W-1:0]    fifo_out_data;
    wire                 busy_now;
    wire                 pulse_a_done;
    wire                 erase_done;
    wire [`DATA_W-1:0]   mem_rd;

    // ****************************************************************
    // Pin decode
    // ****************************************************************
    assign mode        = {mode_line_a, mode_line_b, mode_line_c, mode_line_d};
    assign strobe_rise = pulse_a_strobe_pin & ~strobe_q_ff;
    assign step_rise   = addr_step_pin & ~step_q_ff;
    assign rstpin_rise = reset_vpp_pin & ~rstpin_q_ff;
    assign pulse_a_en     = reset_vpp_pin & vpp_high_pin;
    assign read_en     = reset_vpp_pin & ~vpp_high_pin & pulse_a_strobe_pin;
    assign mem_rd      = flash_mem[addr_ff];

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            strobe_q_ff <= 1'b1;
            step_q_ff   <= 1'b0;
            rstpin_q_ff <= 1'b0;
        end
        else
        begin
            strobe_q_ff <= pulse_a_strobe_pin;
            step_q_ff   <= addr_step_pin;
            rstpin_q_ff <= reset_vpp_pin;
        end
    end

    // ****************************************************************
    // Address counter
    // ****************************************************************
    always @(posedge sys_clk)
    begin
        if (rst)
            addr_ff <= `ADDR_ZERO;
        else if (rstpin_rise)
            addr_ff <= `ADDR_ZERO;
        else if (step_rise)
            addr_ff <= addr_ff + 1'b1;
    end

    // ****************************************************************
    // Write request capture
    // ****************************************************************
    // The write starts when the strobe returns high, so busy follows it
    always @*
    begin
        push_ok = 1'b1;
        push_op = `OP_CODE;
        case (mode)
            `MODE_WRITE_CODE:  push_op = `OP_CODE;
            `MODE_WRITE_LOCK1: push_op = `OP_LOCK1;
            `MODE_WRITE_LOCK2: push_op = `OP_LOCK2;
            default:           push_ok = 1'b0;
        endcase
    end

    // A full queue drops the strobe; busy still shows, held low by the queued writes
    assign push = strobe_rise & pulse_a_en & push_ok & fifo_in_ready;

    // Strobe low time, saturating, for chip erase qualification
    always @(posedge sys_clk)
    begin
        if (rst || pulse_a_strobe_pin)
            low_cnt_ff <= {`TIMER_W{1'b0}};
        else if (low_cnt_ff < ERASE_CYCLES)
            low_cnt_ff <= low_cnt_ff + 1'b1;
    end

    // Erase only from a quiet engine so no queued byte lands afterwards
    assign erase_go = strobe_rise & pulse_a_en & (mode == `MODE_CHIP_ERASE)
                      & (low_cnt_ff >= ERASE_CYCLES)
                      & (state_ff == ST_IDLE) & ~fifo_out_valid;

    write_fifo
    #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    )
    u_write_fifo
    (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({push_op, addr_ff, data_port_in}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign fifo_out_ready = (state_ff == ST_IDLE) & ~erase_go;

    // ****************************************************************
    // Write engine
    // ****************************************************************
    assign pulse_a_done  = (state_ff == ST_PULSE_A) && (timer_ff == WRITE_CYCLES - 1);
    assign erase_done = (state_ff == ST_ERASE) && (sweep_ff == ARRAY_SZ - 1);

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (erase_go)
                    nxt_state = ST_ERASE;
                else if (fifo_out_valid)
                    nxt_state = ST_PULSE_A;
            end
            ST_PULSE_A:
            begin
                if (pulse_a_done)
                    nxt_state = ST_IDLE;
            end
            ST_ERASE:
            begin
                if (erase_done)
                    nxt_state = ST_IDLE;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
            timer_ff <= {`TIMER_W{1'b0}};
            sweep_ff <= `ADDR_ZERO;
            op_ff    <= `OP_CODE;
            waddr_ff <= `ADDR_ZERO;
            wdata_ff <= `ERASED_BYTE;
        end
        else
        begin
            state_ff <= nxt_state;
            if (state_ff == ST_IDLE && fifo_out_valid && fifo_out_ready)
            begin
                {op_ff, waddr_ff, wdata_ff} <= fifo_out_data;
                timer_ff <= {`TIMER_W{1'b0}};
            end
            else if (state_ff == ST_PULSE_A)
            begin
                timer_ff <= timer_ff + 1'b1;
            end
            if (erase_go)
                sweep_ff <= `ADDR_ZERO;
            else if (state_ff == ST_ERASE)
                sweep_ff <= sweep_ff + 1'b1;
        end
    end

    // Lock bits power up unprogrammed; they leave that state only by writes
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            lock_one_ff <= 1'b0;
            lock_two_ff <= 1'b0;
        end
        else if (erase_done)
        begin
            lock_one_ff <= 1'b0;
            lock_two_ff <= 1'b0;
        end
        else if (pulse_a_done && op_ff == `OP_LOCK1)
        begin
            lock_one_ff <= 1'b1;
        end
        else if (pulse_a_done && op_ff == `OP_LOCK2)
        begin
            lock_two_ff <= 1'b1;
        end
    end

    // ****************************************************************
    // Array write port
    // ****************************************************************
    // Programming only clears bits, so a non-blank byte cannot return to
    // a higher value without the erase sweep
    always @*
    begin
        mem_we    = 1'b0;
        mem_waddr = waddr_ff;
        mem_wdata = flash_mem[waddr_ff] & wdata_ff;
        if (state_ff == ST_ERASE)
        begin
            mem_we    = 1'b1;
            mem_waddr = sweep_ff;
            mem_wdata = `ERASED_BYTE;
        end
        else if (pulse_a_done && op_ff == `OP_CODE && !lock_one_ff)
        begin
            mem_we = 1'b1;
        end
    end

    always @(posedge sys_clk)
    begin
        if (mem_we)
        begin
            flash_mem[mem_waddr] <= mem_wdata;
        end
    end

    // ****************************************************************
    // Polling record and ready/busy
    // ****************************************************************
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            last_addr_ff <= `ADDR_ZERO;
            last_data_ff <= `ERASED_BYTE;
        end
        else if (push)
        begin
            last_addr_ff <= addr_ff;
            last_data_ff <= data_port_in;
        end
    end

    assign busy_now = push | erase_go | fifo_out_valid | (state_ff != ST_IDLE);

    always @(posedge sys_clk)
    begin
        if (rst)
            ready_busy_pin_ff <= 1'b1;
        else
            ready_busy_pin_ff <= ~busy_now;
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always @*
    begin
        case (addr_ff)
            `SIG_ADDR_0: sig_byte = SIG_0;
            `SIG_ADDR_1: sig_byte = SIG_1;
            `SIG_ADDR_2: sig_byte = SIG_2;
            default:     sig_byte = `ERASED_BYTE;
        endcase
    end

    // Lock bits have no read mode at all; only their effects show
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            data_port_oe_ff  <= 1'b0;
            data_port_out_ff <= `ERASED_BYTE;
        end
        else if (read_en && mode == `MODE_READ_SIG)
        begin
            data_port_oe_ff  <= 1'b1;
            data_port_out_ff <= sig_byte;
        end
        else if (read_en && mode == `MODE_READ_CODE)
        begin
            data_port_oe_ff <= 1'b1;
            if (lock_one_ff && lock_two_ff)
                data_port_out_ff <= `ERASED_BYTE;
            else if (busy_now && addr_ff == last_addr_ff)
                data_port_out_ff <= {~last_data_ff[7], mem_rd[6:0]};
            else
                data_port_out_ff <= mem_rd;
        end
        else
        begin
            data_port_oe_ff  <= 1'b0;
            data_port_out_ff <= `ERASED_BYTE;
        end
    end

    // ****************************************************************
    // Device reset detect
    // ****************************************************************
    // Step pulses double as oscillator periods while reset is held high
    always @(posedge sys_clk)
    begin
        if (rst || !reset_vpp_pin)
            osc_cnt_ff <= {`OSC_CNT_W{1'b0}};
        else if (step_rise && osc_cnt_ff < `RESET_OSC_EDGES)
            osc_cnt_ff <= osc_cnt_ff + 1'b1;
    end

    always @(posedge sys_clk)
    begin
        if (rst)
            device_reset_ff <= 1'b0;
        else
            device_reset_ff <= reset_vpp_pin
                               & (osc_cnt_ff >= `RESET_OSC_EDGES);
    end

endmodule // parallel_flash_programming_port

`default_nettype wire

// >>> rtl/write_fifo.v
`timescale 1ns/10ps
`default_nettype none

module write_fifo
#(
    parameter WIDTH = 21,
    parameter DEPTH = 8,
    parameter AW    = 3
)
(
    input  wire             sys_clk,
    input  wire             rst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_ff;
    reg [AW-1:0]    rd_ptr_ff;
    reg [AW:0]      count_ff;

    wire do_push;
    wire do_pop;

    assign in_ready  = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign out_data  = store[rd_ptr_ff];
    assign do_push   = in_valid & in_ready;
    assign do_pop    = out_valid & out_ready;

    always @(posedge sys_clk)
    begin
        if (do_push)
        begin
            store[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers wrap by hand so DEPTH need not be a power of two
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_push)
            begin
                if (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1)
                    wr_ptr_ff <= {AW{1'b0}};
                else
                    wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (do_pop)
            begin
                if (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1)
                    rd_ptr_ff <= {AW{1'b0}};
                else
                    rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (do_push && !do_pop)
                count_ff <= count_ff + 1'b1;
            else if (do_pop && !do_push)
                count_ff <= count_ff - 1'b1;
        end
    end

endmodule // write_fifo

`default_nettype wire
